// >>> smoke_alarm_sequencer.sv
/*
  Timing and sequencing core of an ionization smoke alarm with interconnect, plus an
  AXI4-Lite slave for a test control bit and a status word.
  Assumes synchronous comparator inputs and an external resolver for the interconnect wire.
*/
`timescale 1ns/1ns
`include "smoke_alarm_sequencer_defs.svh"

// Summary of operation
// - standby timebase period is 1.67 seconds
// - each standby tick except test and chirp strobes sensing, latches smoke
// - every 40 s pulse indicator, latch battery
// - no smoke sample during test, chirp, horn
// - alarm shortens timebase to 41.5 ms
// - alarm horn on 166 ms, off 83 ms
// - low battery chirps horn 10.5 ms per 40 s
// - battery adjust switch closes only during indicator
// - alarm indicator pulse every second
// - local alarm drives interconnect high
// - high interconnect means remote alarm
// - indicator blinks only on originating unit
// - discharge sink one timebase cycle after local
// - no discharge after remote alarm
// - interconnect input filtered 500 ms
// - remote horn starts 0.45 to 2.2 s
// - wait 3 s before driving interconnect
// - timing pin low keeps strobe active
// - reset clears all timing and state
// - horn cycle completes before new sample acts
// - no chirp in local or remote alarm
module smoke_alarm_sequencer #(
  parameter int unsigned STBY_CYC   = `SAS_T_STBY_US * `SAS_CLK_MHZ,
  parameter int unsigned ALARM_CYC  = `SAS_T_ALARM_US * `SAS_CLK_MHZ,
  parameter int unsigned PULSE_CYC  = `SAS_T_PULSE_US * `SAS_CLK_MHZ,
  parameter int unsigned FILTER_CYC = `SAS_T_FILTER_US * `SAS_CLK_MHZ
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Analog comparator results and oscillator pin
  input  wire logic        smoke_detected,
  input  wire logic        low_battery_detected,
  input  wire logic        timing_capacitor_pin,
  // Interconnect line
  input  wire logic        io_in,
  output logic             io_out,
  output logic             io_oe,
  // Drivers
  output logic             power_strobe,
  output logic             led_drive,
  output logic             battery_trip_adjust,
  output logic             horn_drive_a,
  output logic             horn_drive_b
);

  // --------------------------------------------------------------------------------------
  // Sequencing state
  // --------------------------------------------------------------------------------------
  smoke_alarm_sequencer_pkg::alarm_state_type state;
  smoke_alarm_sequencer_pkg::alarm_state_type next_state;
  smoke_alarm_sequencer_pkg::status_type      status;

  logic [25:0] per_cnt;
  logic [18:0] pulse_cnt;
  logic [23:0] filt_cnt;
  logic [4:0]  led_cnt;
  logic [2:0]  phase;
  logic [6:0]  io_dly;
  logic        strobe_q;
  logic        chirp_q;
  logic        batt_test;
  logic        smoke_latched;
  logic        low_batt;
  logic        discharge;
  logic        test_mode;

  wire         in_alarm   = (state != smoke_alarm_sequencer_pkg::ST_STANDBY);
  wire         in_standby = (state == smoke_alarm_sequencer_pkg::ST_STANDBY);
  wire         in_local   = (state == smoke_alarm_sequencer_pkg::ST_LOCAL);
  wire         in_remote  = (state == smoke_alarm_sequencer_pkg::ST_REMOTE);
  wire [25:0]  per_last   = in_alarm ? 26'(ALARM_CYC - 1) : 26'(STBY_CYC - 1);
  wire         tick       = (per_cnt == per_last);
  wire         pulse_end  = (pulse_cnt == 19'd1);
  wire         changed    = (next_state != state);
  wire         cycle_end  = tick && (phase == `SAS_HORN_CYCLE_TICKS - 3'd1);
  wire [2:0]   next_phase = cycle_end ? 3'd0 : phase + 3'd1;
  wire [4:0]   next_led   = (led_cnt == `SAS_LED_SLOT_TICKS - 5'd1) ? 5'd0 : led_cnt + 5'd1;
  wire         filt_done  = (filt_cnt == 24'(FILTER_CYC - 1));
  wire         smoke_now  = strobe_q && pulse_end && smoke_detected;

  // In standby the slot counter picks battery test, chirp or smoke strobe for each tick.
  wire         sb_batt   = in_standby && tick && (led_cnt == 5'd0);
  wire         sb_chirp  = in_standby && tick && (led_cnt == `SAS_CHIRP_SLOT) &&
                           low_batt;
  wire         sb_strobe = in_standby && tick && !sb_batt && !sb_chirp;
  // In alarm the strobe falls in the first off period, so the horn never masks a sample.
  wire         al_strobe = in_alarm && tick && (next_phase == `SAS_HORN_ON_TICKS);
  wire         al_led    = in_local && tick && (led_cnt == 5'd0);
  wire         start     = sb_batt || sb_chirp || sb_strobe || al_strobe || al_led;

  // --------------------------------------------------------------------------------------
  // Alarm state decision
  // --------------------------------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      smoke_alarm_sequencer_pkg::ST_STANDBY: begin
        if (smoke_now || test_mode) begin
          next_state = smoke_alarm_sequencer_pkg::ST_LOCAL;
        end else if (filt_done && io_in) begin
          next_state = smoke_alarm_sequencer_pkg::ST_REMOTE;
        end
      end
      smoke_alarm_sequencer_pkg::ST_LOCAL: begin
        if (cycle_end && !smoke_latched && !test_mode) begin
          next_state = smoke_alarm_sequencer_pkg::ST_STANDBY;
        end
      end
      smoke_alarm_sequencer_pkg::ST_REMOTE: begin
        if (cycle_end && (smoke_latched || test_mode)) begin
          next_state = smoke_alarm_sequencer_pkg::ST_LOCAL;
        end else if (cycle_end && !io_in) begin
          next_state = smoke_alarm_sequencer_pkg::ST_STANDBY;
        end
      end
      default: begin
        next_state = smoke_alarm_sequencer_pkg::ST_STANDBY;
      end
    endcase
  end

  wire next_alarm  = (next_state != smoke_alarm_sequencer_pkg::ST_STANDBY);
  wire leave_local = in_local && changed;
  wire next_dump   = leave_local ? 1'b1 : ((changed || tick) ? 1'b0 : discharge);
  wire next_io_drv = (next_state == smoke_alarm_sequencer_pkg::ST_LOCAL) && !changed &&
                     (io_dly == `SAS_IO_DELAY_TICKS);
  wire strobe_nx   = start ? (sb_strobe || al_strobe) : (strobe_q && !pulse_end);
  // A running chirp is cut short when an alarm takes over; one started on the tick that enters alarm lasts one cycle into it.
  wire chirp_nx    = start ? sb_chirp : (chirp_q && !pulse_end && !next_alarm);
  wire led_nx      = start ? (sb_batt || al_led) : (led_drive && !pulse_end);
  wire batt_nx     = start ? sb_batt : (batt_test && !pulse_end);
  wire horn_nx     = (next_alarm && !changed) ? (next_phase < `SAS_HORN_ON_TICKS) && tick ||
                     (phase < `SAS_HORN_ON_TICKS) && !tick :
                     (next_alarm || chirp_nx);

  // --------------------------------------------------------------------------------------
  // Timebase and pulses
  // --------------------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= smoke_alarm_sequencer_pkg::ST_STANDBY;
      per_cnt <= 26'd0;
      phase <= 3'd0;
      led_cnt <= 5'd0;
      pulse_cnt <= 19'd0;
    end else begin
      state <= next_state;
      per_cnt <= (tick || changed) ? 26'd0 : per_cnt + 26'd1;
      phase <= changed ? 3'd0 : (tick ? next_phase : phase);
      led_cnt <= changed ? 5'd0 : (tick ? next_led : led_cnt);
      pulse_cnt <= start ? 19'(PULSE_CYC) : (pulse_cnt != 19'd0 ? pulse_cnt - 19'd1 : 19'd0);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe_q <= 1'b0;
      chirp_q <= 1'b0;
      batt_test <= 1'b0;
      led_drive <= 1'b0;
      battery_trip_adjust <= 1'b0;
      power_strobe <= 1'b0;
      horn_drive_a <= 1'b0;
      horn_drive_b <= 1'b0;
    end else begin
      strobe_q <= strobe_nx;
      chirp_q <= chirp_nx;
      batt_test <= batt_nx;
      led_drive <= led_nx;
      battery_trip_adjust <= batt_nx;
      power_strobe <= strobe_nx || !timing_capacitor_pin;
      horn_drive_a <= horn_nx;
      horn_drive_b <= horn_nx;
    end
  end

  // --------------------------------------------------------------------------------------
  // Latches, interconnect filter and drive
  // --------------------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      smoke_latched <= 1'b0;
      low_batt <= 1'b0;
      filt_cnt <= 24'd0;
      io_dly <= 7'd0;
      discharge <= 1'b0;
      io_out <= 1'b0;
      io_oe <= 1'b0;
    end else begin
      if (strobe_q && pulse_end) begin
        smoke_latched <= smoke_detected;
      end
      if (batt_test && pulse_end) begin
        low_batt <= low_battery_detected;
      end
      // Our own sink would read as a low, so the filter sleeps while discharging.
      filt_cnt <= (in_standby && io_in && !discharge && !filt_done) ?
                  filt_cnt + 24'd1 : 24'd0;
      io_dly <= !in_local || changed ? 7'd0 :
                ((tick && io_dly != `SAS_IO_DELAY_TICKS) ? io_dly + 7'd1 : io_dly);
      discharge <= next_dump;
      io_out <= next_io_drv;
      io_oe <= next_io_drv || next_dump;
    end
  end

  assign status = '{io_drive: io_out, discharge: discharge, smoke_latched: smoke_latched,
                     low_battery: low_batt, remote_alarm: in_remote, local_alarm: in_local};

  // --------------------------------------------------------------------------------------
  // AXI4-Lite slave
  // --------------------------------------------------------------------------------------
  logic [3:0]  aw_addr_q;
  logic        aw_have;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        w_have;

  wire do_write  = aw_have && w_have && !bvalid;
  wire wr_ctrl   = (aw_addr_q == `SAS_ADDR_CTRL);
  wire wr_ok     = wr_ctrl || (aw_addr_q == `SAS_ADDR_STATUS);
  wire rd_ctrl   = (araddr == `SAS_ADDR_CTRL);
  wire rd_stat   = (araddr == `SAS_ADDR_STATUS);
  wire [31:0] rd_value = rd_ctrl ? {31'd0, test_mode} :
                         (rd_stat ? {26'd0, status} : 32'd0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'd0;
      w_strb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `SAS_RESP_OKAY;
      test_mode <= `SAS_CTRL_RESET;
    end else begin
      awready <= !aw_have && !awready && awvalid;
      wready <= !w_have && !wready && wvalid;
      if (awvalid && awready) begin
        aw_have <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_have <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (do_write) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_ok ? `SAS_RESP_OKAY : `SAS_RESP_SLVERR;
        if (wr_ctrl && w_strb_q[0]) begin
          test_mode <= w_data_q[`SAS_CTRL_TEST_BIT];
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'd0;
      rresp <= `SAS_RESP_OKAY;
    end else begin
      arready <= !arready && !rvalid && arvalid;
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= rd_value;
        rresp <= (rd_ctrl || rd_stat) ? `SAS_RESP_OKAY : `SAS_RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------------------
  property p_batt_no_smoke;
    @(posedge aclk) disable iff (!aresetn) (battery_trip_adjust || chirp_q) |-> !strobe_q;
  endproperty
  a_batt_no_smoke: assert property (p_batt_no_smoke) else $error("strobe during test");

  property p_adjust_with_led;
    @(posedge aclk) disable iff (!aresetn) battery_trip_adjust |-> led_drive;
  endproperty
  a_adjust_with_led: assert property (p_adjust_with_led) else $error("adjust without led");

  property p_pulse_ends;
    @(posedge aclk) disable iff (!aresetn) (pulse_end && !start) |=> !led_drive && !strobe_q;
  endproperty
  a_pulse_ends: assert property (p_pulse_ends) else $error("pulse overran");

  property p_horn_off_phase;
    @(posedge aclk) disable iff (!aresetn)
      (in_alarm && tick && phase == 3'd3 && !changed) |=> !horn_drive_a ##1 !horn_drive_a;
  endproperty
  a_horn_off_phase: assert property (p_horn_off_phase) else $error("horn not off");

  property p_remote_no_led;
    @(posedge aclk) disable iff (!aresetn) (in_remote && tick) |=> !led_drive;
  endproperty
  a_remote_no_led: assert property (p_remote_no_led) else $error("led in remote");

  property p_dump_after_local;
    @(posedge aclk) disable iff (!aresetn)
      ($past(in_local) && in_standby) |-> io_oe && !io_out;
  endproperty
  a_dump_after_local: assert property (p_dump_after_local) else $error("no discharge");

  property p_no_dump_remote;
    @(posedge aclk) disable iff (!aresetn) ($past(in_remote) && in_standby) |-> !io_oe;
  endproperty
  a_no_dump_remote: assert property (p_no_dump_remote) else $error("discharge on remote");

  property p_drive_local;
    @(posedge aclk) disable iff (!aresetn) io_out |-> in_local && io_dly == 7'd72;
  endproperty
  a_drive_local: assert property (p_drive_local) else $error("early drive");

  property p_filter;
    @(posedge aclk) disable iff (!aresetn)
      $rose(in_remote) |-> $past(filt_cnt) == 24'(FILTER_CYC - 1);
  endproperty
  a_filter: assert property (p_filter) else $error("remote without filter");

  property p_test_strobe;
    @(posedge aclk) disable iff (!aresetn) !timing_capacitor_pin |=> power_strobe;
  endproperty
  a_test_strobe: assert property (p_test_strobe) else $error("strobe not forced");

  property p_no_chirp_alarm;
    @(posedge aclk) disable iff (!aresetn) chirp_q |-> in_standby && low_batt;
  endproperty
  a_no_chirp_alarm: assert property (p_no_chirp_alarm) else $error("chirp in alarm");

endmodule : smoke_alarm_sequencer

// >>> smoke_alarm_sequencer_defs.svh
/*
  Constants of the smoke alarm sequencer: register offsets, field positions, reset values
  and timing figures. Assumes the including file derives cycle counts from these times.
*/
`ifndef SMOKE_ALARM_SEQUENCER_DEFS_SVH
`define SMOKE_ALARM_SEQUENCER_DEFS_SVH

// ----------------------------------------------------------------------------------------
// Clock and times
// ----------------------------------------------------------------------------------------
`define SAS_CLK_MHZ          25
`define SAS_T_STBY_US        1670000
`define SAS_T_ALARM_US       41500
`define SAS_T_PULSE_US       10500
`define SAS_T_FILTER_US      500000

// ----------------------------------------------------------------------------------------
// Counts of timebase periods
// ----------------------------------------------------------------------------------------
`define SAS_LED_SLOT_TICKS   5'd24
`define SAS_CHIRP_SLOT       5'd12
`define SAS_HORN_ON_TICKS    3'd4
`define SAS_HORN_CYCLE_TICKS 3'd6
`define SAS_IO_DELAY_TICKS   7'd72

// ----------------------------------------------------------------------------------------
// Registers
// ----------------------------------------------------------------------------------------
`define SAS_ADDR_CTRL        4'h0
`define SAS_ADDR_STATUS      4'h4
`define SAS_CTRL_RESET       1'b0
`define SAS_CTRL_TEST_BIT    0
`define SAS_RESP_OKAY        2'b00
`define SAS_RESP_SLVERR      2'b10

`endif

// >>> smoke_alarm_sequencer_pkg.sv
/*
  Types shared by the smoke alarm sequencer.
  Assumes nothing of its surroundings.
*/
package smoke_alarm_sequencer_pkg;

  typedef enum logic [2:0] {
    ST_STANDBY = 3'b001,
    ST_LOCAL   = 3'b010,
    ST_REMOTE  = 3'b100
  } alarm_state_type;

  typedef struct packed {
    logic io_drive;
    logic discharge;
    logic smoke_latched;
    logic low_battery;
    logic remote_alarm;
    logic local_alarm;
  } status_type;

endpackage : smoke_alarm_sequencer_pkg

// >>> peer_detector.sv
/*
  Behavioural model of another detector sharing the interconnect line.
  Assumes the bench resolves the wire from every driver and feeds it back here.
*/
`timescale 1ns/1ns

// ----------------------------------------------------------------------------
// Peer unit
// ----------------------------------------------------------------------------
module peer_detector (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Alarm command and resolved line
  input  wire logic alarm_cmd,
  input  wire logic line,
  output logic      drive,
  output logic      heard
);
  // A peer in alarm drives the line high, and the resolved line is registered into heard.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive <= 1'h0;
      heard <= 1'h0;
    end else begin
      drive <= alarm_cmd;
      heard <= line;
    end
  end
endmodule : peer_detector

// >>> testbench.sv
/*
  Self-checking bench for the smoke alarm sequencer with one peer on the line.
  Assumes shortened timing parameters; the idle line is pulled low.
*/
`timescale 1ns/1ns

module testbench;
  localparam int STBY = 200;
  localparam int ALRM = 40;
  localparam int PULS = 8;
  localparam int FILT = 100;
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        smoke_detected = 1'h0, low_battery_detected = 1'h0;
  logic        timing_capacitor_pin = 1'h1, peer_cmd = 1'h0;
  logic        io_out, io_oe, power_strobe, led_drive, battery_trip_adjust;
  logic        horn_drive_a, horn_drive_b, peer_drive, peer_heard;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  logic [31:0] rnd = 32'hd23f_a419;
  logic [33:0] t, u, s;
  logic [33:0] cyc = 34'h0_0000_0000;
  int          error_cnt = 0;
  int          checks = 0;
  // The sink wins over a peer, so a dump always shows as a low line.
  wire io_in = (io_oe && !io_out) ? 1'h0 : ((io_oe && io_out) || peer_drive);

  always #20 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 34'h1;

  smoke_alarm_sequencer #(.STBY_CYC(STBY), .ALARM_CYC(ALRM), .PULSE_CYC(PULS),
    .FILTER_CYC(FILT)) dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .smoke_detected, .low_battery_detected,
    .timing_capacitor_pin, .io_in, .io_out, .io_oe, .power_strobe, .led_drive,
    .battery_trip_adjust, .horn_drive_a, .horn_drive_b);
  peer_detector peer (.aclk, .aresetn, .alarm_cmd(peer_cmd), .line(io_in),
    .drive(peer_drive), .heard(peer_heard));

  // --------------------------------------------------------------------------
  // Checking helpers
  // --------------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  function automatic logic pick(input int w);
    case (w)
      0: return power_strobe;
      1: return led_drive;
      2: return horn_drive_a;
      3: return io_oe && io_out;
      default: return io_oe && !io_out;
    endcase
  endfunction : pick

  task automatic tally_and_finish();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic give_up(input string n);
    error_cnt++;
    $display("[ERR] %s expected response seen none", n);
    tally_and_finish();
  endtask : give_up

  task automatic wait_lvl(input int w, input logic v, input int bound, output logic [33:0] n);
    n = 34'h0;
    while (pick(w) !== v) begin
      @(posedge aclk);
      n++;
      if (n > bound) give_up("level wait");
    end
  endtask : wait_lvl

  task automatic hold_lvl(input int w, input logic v, input int n, input string nm);
    logic bad;
    bad = 1'h0;
    repeat (n) begin
      @(posedge aclk);
      if (pick(w) !== v) bad = 1'h1;
    end
    chk(nm, 34'h0, {33'h0, bad});
  endtask : hold_lvl

  // --------------------------------------------------------------------------
  // Bus master; results are noted here and compared by the watcher below
  // --------------------------------------------------------------------------
  task automatic axi_wr(input logic [3:0] a, input logic [3:0] st, input logic [31:0] d,
                        input logic [1:0] r);
    int  n;
    logic ad, wd;
    ad = 1'h0;
    wd = 1'h0;
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    wstrb <= st;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; !(ad && wd); n++) begin
      @(posedge aclk);
      if (awready && !ad) begin
        ad = 1'h1;
        awvalid <= 1'h0;
      end
      if (wready && !wd) begin
        wd = 1'h1;
        wvalid <= 1'h0;
      end
      if (n > 50) give_up("write address or data");
    end
    for (n = 0; bvalid !== 1'h1; n++) begin
      @(posedge aclk);
      if (n > 50) give_up("write response");
    end
    bready <= 1'h0;
    @(posedge aclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    rq.push_back({r, d});
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; arready !== 1'h1; n++) begin
      @(posedge aclk);
      if (n > 50) give_up("read address");
    end
    arvalid <= 1'h0;
    for (n = 0; rvalid !== 1'h1; n++) begin
      @(posedge aclk);
      if (n > 50) give_up("read data");
    end
    rready <= 1'h0;
    @(posedge aclk);
  endtask : axi_rd

  always @(posedge aclk) begin
    if (bvalid && bready) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
    if (rvalid && rready) chk("rresp rdata", rq.pop_front(), {rresp, rdata});
    if (battery_trip_adjust && !led_drive) chk("adjust outside pulse", 34'h0, 34'h1);
    if (horn_drive_b !== horn_drive_a) chk("horn pair", {33'h0, horn_drive_a}, {33'h0, horn_drive_b});
  end

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk("outputs", 34'h0, {30'h0, io_oe, power_strobe, led_drive, horn_drive_a});
    axi_rd(4'h0, 32'h0000_0000, 2'h0);
    axi_rd(4'h4, 32'h0000_0000, 2'h0);
    axi_rd(4'h8, 32'h0000_0000, 2'h2);
    wait_lvl(0, 1'h1, 2 * STBY, t);
    wait_lvl(0, 1'h0, PULS + 1, t);
    chk("strobe width", 34'(PULS), t);
    wait_lvl(0, 1'h1, STBY, u);
    chk("strobe period", 34'(STBY), t + u);
    low_battery_detected <= 1'h1;
    wait_lvl(1, 1'h1, 25 * STBY, t);
    chk("adjust in pulse", 34'h1, {33'h0, battery_trip_adjust});
    chk("no sample in test", 34'h0, {33'h0, power_strobe});
    wait_lvl(1, 1'h0, PULS + 1, t);
    chk("led width", 34'(PULS), t);
    wait_lvl(1, 1'h1, 24 * STBY, u);
    chk("led period", 34'(24 * STBY), t + u);
    for (int i = 0; i < 2; i++) begin
      wait_lvl(2, 1'h1, 24 * STBY, u);
      chk("no sample in chirp", 34'h0, {33'h0, power_strobe});
      if (i == 1) chk("chirp period", 34'(24 * STBY), t + u);
      wait_lvl(2, 1'h0, PULS + 1, t);
      chk("chirp width", 34'(PULS), t);
    end
    axi_rd(4'h4, 32'h0000_0004, 2'h0);
    low_battery_detected <= 1'h0;
    wait_lvl(1, 1'h1, 24 * STBY, t);
    wait_lvl(1, 1'h0, PULS + 1, t);
    smoke_detected <= 1'h1;
    wait_lvl(2, 1'h1, 3 * STBY, t);
    s = cyc;
    wait_lvl(2, 1'h0, 5 * ALRM, t);
    chk("horn on", 34'(4 * ALRM), t);
    wait_lvl(2, 1'h1, 3 * ALRM, u);
    chk("horn off", 34'(2 * ALRM), u);
    wait_lvl(1, 1'h1, 25 * ALRM, t);
    wait_lvl(1, 1'h0, PULS + 1, t);
    wait_lvl(1, 1'h1, 25 * ALRM, u);
    chk("alarm led period", 34'(24 * ALRM), t + u);
    wait_lvl(3, 1'h1, 75 * ALRM, t);
    t = cyc - s;
    chk("io delay", 34'h1, {33'h0, t >= 71 * ALRM && t <= 73 * ALRM});
    repeat (2) @(posedge aclk);
    chk("peer hears", 34'h1, {33'h0, peer_heard});
    axi_rd(4'h4, 32'h0000_0029, 2'h0);
    smoke_detected <= 1'h0;
    wait_lvl(4, 1'h1, 30 * ALRM, t);
    wait_lvl(4, 1'h0, STBY + 1, t);
    chk("dump length", 34'(STBY), t);
    peer_cmd <= 1'h1;
    hold_lvl(2, 1'h0, FILT - 10, "short pulse horn");
    peer_cmd <= 1'h0;
    hold_lvl(2, 1'h0, 300, "short pulse horn");
    peer_cmd <= 1'h1;
    wait_lvl(2, 1'h1, 500, t);
    chk("remote delay", 34'h1, {33'h0, t >= FILT * 9 / 10 && t <= FILT * 22 / 5});
    hold_lvl(1, 1'h0, 30 * ALRM, "remote led");
    axi_rd(4'h4, 32'h0000_0002, 2'h0);
    peer_cmd <= 1'h0;
    hold_lvl(4, 1'h0, 600, "remote dump");
    rnd = lfsr(rnd);
    axi_wr(4'h0, 4'he, rnd | 32'h0000_0001, 2'h0);
    axi_rd(4'h0, 32'h0000_0000, 2'h0);
    axi_wr(4'h4, 4'hf, rnd, 2'h0);
    axi_wr(4'hc, 4'hf, rnd, 2'h2);
    axi_wr(4'h0, 4'hf, rnd | 32'h0000_0001, 2'h0);
    axi_rd(4'h0, 32'h0000_0001, 2'h0);
    wait_lvl(2, 1'h1, 100, t);
    rnd = lfsr(rnd);
    axi_wr(4'h0, 4'hf, rnd & 32'hffff_fffe, 2'h0);
    wait_lvl(4, 1'h1, 30 * ALRM, t);
    wait_lvl(4, 1'h0, STBY + 1, t);
    chk("test dump length", 34'(STBY), t);
    timing_capacitor_pin <= 1'h0;
    repeat (2) @(posedge aclk);
    hold_lvl(0, 1'h1, 50, "strobe held");
    timing_capacitor_pin <= 1'h1;
    axi_wr(4'h0, 4'hf, 32'h0000_0001, 2'h0);
    wait_lvl(2, 1'h1, 100, t);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    chk("outputs in reset", 34'h0, {31'h0, io_oe, led_drive, horn_drive_a});
    aresetn <= 1'h1;
    @(posedge aclk);
    axi_rd(4'h0, 32'h0000_0000, 2'h0);
    chk("queues drained", 34'h0, 34'(bq.size() + rq.size()));
    tally_and_finish();
  end
endmodule : testbench
